// [rtl/flag_irq_timer_pins.sv]
// program flag pins, interrupt request pins and timer-expiry pin with strap capture
//
// Implementation choices: the address map and the strobed register port.
module flag_irq_timer_pins (
  input  wire logic                                 clock,
  input  wire logic                                 reset,
  input  wire logic [flag_irq_pkg::ADDR_W-1:0]      reg_addr,
  input  wire logic [flag_irq_pkg::DATA_W-1:0]      reg_wdata,
  input  wire logic                                 reg_write,
  input  wire logic                                 reg_read,
  output logic      [flag_irq_pkg::DATA_W-1:0]      reg_rdata,
  input  wire logic [flag_irq_pkg::FLAG_COUNT-1:0]  program_flag_pins_level,
  output logic      [flag_irq_pkg::FLAG_COUNT-1:0]  program_flag_pins_value,
  output logic      [flag_irq_pkg::FLAG_COUNT-1:0]  program_flag_pins_oe,
  output logic      [flag_irq_pkg::FLAG_COUNT-1:0]  flag_cond,
  input  wire logic [flag_irq_pkg::IRQ_COUNT-1:0]   interrupt_request_pins_n,
  output logic      [flag_irq_pkg::IRQ_COUNT-1:0]   irq_to_core,
  input  wire logic                                 vectors_ready,
  input  wire logic                                 timer0_expired,
  input  wire logic                                 timer_expire_out_level,
  output logic                                      timer_expire_out_value,
  output logic                                      timer_expire_out_oe
);
  import flag_irq_pkg::*;

  logic [FLAG_COUNT-1:0] flag_dir_q;
  logic [FLAG_COUNT-1:0] flag_out_q;
  logic [FLAG_COUNT-1:0] flag_sync;
  logic [IRQ_COUNT-1:0]  irq_sync;
  logic [IRQ_COUNT-1:0]  irq_en_q;
  logic [IRQ_COUNT-1:0]  irq_mode_q;
  logic [DATA_W-1:0]     rdata_q;
  boot_state_t           boot_q;
  logic                  strap_q;
  logic                  boot_irq;
  logic [7:0]            pulse_cnt_q;
  logic [7:0]            pulse_cnt_d;
  logic                  tmr_out_q;
  logic                  wr_dir;
  logic                  wr_out;
  logic                  wr_en;
  logic                  wr_mode;
  logic                  wr_pend;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  assign wr_dir  = reg_write && (reg_addr == OFS_FLAG_DIR);
  assign wr_out  = reg_write && (reg_addr == OFS_FLAG_OUT);
  assign wr_en   = reg_write && (reg_addr == OFS_IRQ_EN);
  assign wr_mode = reg_write && (reg_addr == OFS_IRQ_MODE);
  assign wr_pend = reg_write && (reg_addr == OFS_IRQ_PEND);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flag_dir_q <= FLAG_DIR_RST;
    end else if (wr_dir) begin
      flag_dir_q <= reg_wdata[FLAG_COUNT-1:0];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flag_out_q <= FLAG_OUT_RST;
    end else if (wr_out) begin
      flag_out_q <= reg_wdata[FLAG_COUNT-1:0];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_en_q <= IRQ_EN_RST;
    end else if (wr_en) begin
      irq_en_q <= reg_wdata[IRQ_COUNT-1:0];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_mode_q <= IRQ_MODE_RST;
    end else if (wr_mode) begin
      irq_mode_q <= reg_wdata[IRQ_COUNT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // flag pins
  // ----------------------------------------------------------------
  // the pin level is sampled even while driven, so software sees any contention
  pin_sync #(
    .WIDTH       (FLAG_COUNT),
    .RESET_VALUE (PIN_IDLE_RST)
  ) u_flag_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in (program_flag_pins_level),
    .sync_out (flag_sync)
  );

  assign program_flag_pins_oe    = flag_dir_q;
  assign program_flag_pins_value = flag_out_q;
  assign flag_cond               = flag_sync;

  // ----------------------------------------------------------------
  // interrupt request pins
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH       (IRQ_COUNT),
    .RESET_VALUE (PIN_IDLE_RST)
  ) u_irq_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in (interrupt_request_pins_n),
    .sync_out (irq_sync)
  );

  irq_ctl_if #(.N(IRQ_COUNT)) irq_bus ();

  // boot by interrupt opens every line once vectors are in place
  assign boot_irq = (boot_q == BS_RUN) && (strap_q == STRAP_IRQ_BOOT) && vectors_ready;

  assign irq_bus.req_n_sync = irq_sync;
  assign irq_bus.edge_mode  = irq_mode_q;
  assign irq_bus.enable     = irq_en_q | {IRQ_COUNT{boot_irq}};
  assign irq_bus.clear      = wr_pend ? reg_wdata[IRQ_COUNT-1:0] : '0;
  assign irq_to_core        = irq_bus.irq;

  irq_detect #(.N(IRQ_COUNT)) u_irq_detect (
    .clock (clock),
    .reset (reset),
    .bus   (irq_bus.det)
  );

  // ----------------------------------------------------------------
  // strap capture and timer-expiry pin
  // ----------------------------------------------------------------
  // the pin stays undriven through reset and the first edge after it,
  // so the external strap level is what gets sampled
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      boot_q  <= BS_CAPTURE;
      strap_q <= 1'b0;
    end else begin
      case (boot_q)
        BS_CAPTURE: begin
          strap_q <= timer_expire_out_level;
          boot_q  <= BS_RUN;
        end
        BS_RUN: begin
          boot_q <= BS_RUN;
        end
        default: begin
          boot_q <= BS_CAPTURE;
        end
      endcase
    end
  end

  // a new expiry restarts the pulse rather than extending a queue of them
  always_comb begin
    pulse_cnt_d = pulse_cnt_q;
    if ((boot_q == BS_RUN) && timer0_expired) begin
      pulse_cnt_d = EXPIRE_PULSE_CYCLES;
    end else if (pulse_cnt_q != 8'h00) begin
      pulse_cnt_d = pulse_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pulse_cnt_q <= 8'h00;
      tmr_out_q   <= 1'b0;
    end else begin
      pulse_cnt_q <= pulse_cnt_d;
      tmr_out_q   <= (pulse_cnt_d != 8'h00);
    end
  end

  assign timer_expire_out_value = tmr_out_q;
  assign timer_expire_out_oe    = (boot_q == BS_RUN);

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (reg_read) begin
      rdata_q <= '0;
      case (reg_addr)
        OFS_FLAG_DIR: rdata_q[FLAG_COUNT-1:0] <= flag_dir_q;
        OFS_FLAG_OUT: rdata_q[FLAG_COUNT-1:0] <= flag_out_q;
        OFS_FLAG_IN:  rdata_q[FLAG_COUNT-1:0] <= flag_sync;
        OFS_IRQ_EN:   rdata_q[IRQ_COUNT-1:0]  <= irq_en_q;
        OFS_IRQ_MODE: rdata_q[IRQ_COUNT-1:0]  <= irq_mode_q;
        OFS_IRQ_PEND: rdata_q[IRQ_COUNT-1:0]  <= irq_bus.pending;
        OFS_STATUS: begin
          rdata_q[STATUS_STRAP_BIT]  <= strap_q;
          rdata_q[STATUS_BOOT_BIT]   <= boot_irq;
          rdata_q[STATUS_VECTOR_BIT] <= vectors_ready;
        end
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_capture_then_run;
    (boot_q == BS_CAPTURE) ##1 (boot_q == BS_RUN);
  endsequence

  sequence s_pin_driven;
    timer_expire_out_oe [*3];
  endsequence

  a_flag_dir_write: assert property (wr_dir |=>
    (program_flag_pins_oe == $past(reg_wdata[FLAG_COUNT-1:0])))
    else $error("flag direction did not take the written value");

  a_flag_input_reset: assert property (@(posedge clock)
    $fell(reset) |-> (program_flag_pins_oe == 4'h0))
    else $error("flag pins not inputs after reset");

  a_flag_cond_path: assert property (
    (!$past(reset) && !$past(reset, 2)) |-> (flag_cond == $past(program_flag_pins_level, 2)))
    else $error("flag condition lags its pin by other than two cycles");

  a_irq_gate_off: assert property (
    (!boot_irq && (irq_en_q == 4'h0)) |-> (irq_to_core == 4'h0))
    else $error("interrupt raised while lines disabled");

  a_strap_sample: assert property (
    (boot_q == BS_CAPTURE) |-> (!timer_expire_out_oe ##1
      (strap_q == $past(timer_expire_out_level))))
    else $error("strap not sampled from the undriven pin");

  a_strap_then_drive: assert property (
    s_capture_then_run |-> s_pin_driven)
    else $error("expiry pin not driven after strap capture");

  a_expire_pulse: assert property (
    ((boot_q == BS_RUN) && timer0_expired) |=> (timer_expire_out_value ##1
      (timer_expire_out_value || $past(timer0_expired) || (EXPIRE_PULSE_CYCLES == 8'h01))))
    else $error("expiry pulse missing after timer 0 expiry");

  a_read_dir: assert property ((reg_read && (reg_addr == OFS_FLAG_DIR)) |=>
    (reg_rdata == {28'h0000000, $past(flag_dir_q)}))
    else $error("direction read-back wrong");
endmodule

// [rtl/flag_irq_pkg.sv]
// shared constants for the flag, interrupt request and timer-expiry pin block
package flag_irq_pkg;

  localparam int FLAG_COUNT = 4;
  localparam int IRQ_COUNT  = 4;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FLAG_DIR = 8'h00;
  localparam logic [7:0] OFS_FLAG_OUT = 8'h04;
  localparam logic [7:0] OFS_FLAG_IN  = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MODE = 8'h10;
  localparam logic [7:0] OFS_IRQ_PEND = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;

  // ----------------------------------------------------------------
  // values after reset and field positions
  // ----------------------------------------------------------------
  localparam logic [3:0] FLAG_DIR_RST = 4'h0;
  localparam logic [3:0] FLAG_OUT_RST = 4'h0;
  localparam logic [3:0] IRQ_EN_RST   = 4'h0;
  localparam logic [3:0] IRQ_MODE_RST = 4'h0;
  localparam logic [3:0] PIN_IDLE_RST = 4'hF;
  localparam int STATUS_STRAP_BIT  = 0;
  localparam int STATUS_BOOT_BIT   = 1;
  localparam int STATUS_VECTOR_BIT = 2;

  // strap level on the timer-expiry pin that selects interrupt booting
  localparam logic STRAP_IRQ_BOOT = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int EXPIRE_PULSE_NS = 40;
  localparam logic [7:0] EXPIRE_PULSE_CYCLES =
    8'((EXPIRE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

  typedef enum logic [0:0] {
    BS_CAPTURE = 1'b0,
    BS_RUN     = 1'b1
  } boot_state_t;

endpackage

// [rtl/irq_ctl_if.sv]
// control and status signals between the pin block and its interrupt detector
interface irq_ctl_if #(parameter int N = 4);
  logic [N-1:0] req_n_sync;
  logic [N-1:0] edge_mode;
  logic [N-1:0] enable;
  logic [N-1:0] clear;
  logic [N-1:0] pending;
  logic [N-1:0] irq;

  modport ctl (output req_n_sync, output edge_mode, output enable, output clear,
               input pending, input irq);
  modport det (input req_n_sync, input edge_mode, input enable, input clear,
               output pending, output irq);
endinterface

// [rtl/pin_sync.sv]
// two-flop synchroniser for a group of asynchronous pin inputs
module pin_sync #(
  parameter int               WIDTH       = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_q   <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

  a_sync_delay: assert property (@(posedge clock) disable iff (reset)
    (!$past(reset) && !$past(reset, 2)) |-> (sync_out == $past(async_in, 2)))
    else $error("synchroniser output does not follow input after two cycles");
endmodule

// [rtl/irq_detect.sv]
// per-line edge or level detection for the active-low interrupt request pins
module irq_detect #(
  parameter int N = 4
) (
  input  wire logic clock,
  input  wire logic reset,
  irq_ctl_if.det    bus
);
  logic [N-1:0] prev_q;
  logic [N-1:0] pend_q;
  logic [N-1:0] fall;
  logic [N-1:0] irq_w;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prev_q <= '1;
    end else begin
      prev_q <= bus.req_n_sync;
    end
  end

  assign fall = prev_q & ~bus.req_n_sync;

  for (genvar i = 0; i < N; i++) begin : g_line
    // a capture in the clearing cycle wins so no edge is lost
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        pend_q[i] <= 1'b0;
      end else if (bus.enable[i] && bus.edge_mode[i] && fall[i]) begin
        pend_q[i] <= 1'b1;
      end else if (bus.clear[i] || !bus.enable[i]) begin
        pend_q[i] <= 1'b0;
      end
    end

    // level lines follow the pin; edge lines hold until cleared
    assign irq_w[i] = bus.enable[i] &&
                      (bus.edge_mode[i] ? pend_q[i] : !bus.req_n_sync[i]);

    a_edge_latch: assert property (
      (bus.enable[i] && bus.edge_mode[i] && fall[i]) |=> (pend_q[i] ##1 1'b1))
      else $error("falling edge on an enabled edge line was not captured");
    a_set_wins: assert property (
      (bus.enable[i] && bus.edge_mode[i] && fall[i] && bus.clear[i]) |=> pend_q[i])
      else $error("clear in the same cycle swallowed an edge");
    a_level_pass: assert property (
      (bus.enable[i] && !bus.edge_mode[i]) |-> (irq_w[i] == !bus.req_n_sync[i]))
      else $error("level line request does not track the pin");
    a_quiet_off: assert property (
      !bus.enable[i] |-> !irq_w[i])
      else $error("disabled line raised an interrupt");
  end

  assign bus.pending = pend_q;
  assign bus.irq     = irq_w;
endmodule

// [bench/pin_partner.sv]
// board-side model of the parts driving the flag, request and expiry pins
module pin_partner (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [3:0] flag_drive,
  input  wire logic [3:0] flag_drive_en,
  input  wire logic [3:0] flag_dut_value,
  input  wire logic [3:0] flag_dut_oe,
  output logic      [3:0] flag_level,
  input  wire logic [3:0] irq_n_cmd,
  output logic      [3:0] irq_n,
  input  wire logic       strap,
  input  wire logic       expire_value,
  input  wire logic       expire_oe,
  output logic            expire_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hold_q;

  // ---------------------------------------------
  // strap driver
  // ---------------------------------------------
  // the strap stays on the wire up to the first edge after reset ends
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hold_q <= 1'b1;
    end else begin
      hold_q <= 1'b0;
    end
  end

  // ---------------------------------------------
  // wire levels
  // ---------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // released flag pins float up through their pull-ups
      flag_level[i] = flag_dut_oe[i] ? flag_dut_value[i] :
                      (flag_drive_en[i] ? flag_drive[i] : 1'b1);
    end
    irq_n = irq_n_cmd;
    // no pull on the expiry pin: an undriven wire shows the opposite of the strap
    expire_level = expire_oe ? expire_value : (hold_q ? strap : ~strap);
  end
endmodule

// [bench/test_flag_irq_timer_pins.sv]
// self-checking bench for the flag, request and expiry pin block
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module test_flag_irq_timer_pins;
  timeunit 1ns;
  timeprecision 1ns;
  import flag_irq_pkg::*;
  logic              clock;
  logic              reset;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] rv;
  logic              reg_write;
  logic              reg_read;
  logic [3:0]        flag_level;
  logic [3:0]        flag_value;
  logic [3:0]        flag_oe;
  logic [3:0]        flag_cond;
  logic [3:0]        flag_drive;
  logic [3:0]        flag_drive_en;
  logic [3:0]        irq_n_cmd;
  logic [3:0]        irq_n;
  logic [3:0]        irq_to_core;
  logic              vectors_ready;
  logic              timer0_expired;
  logic              strap;
  logic              exp_level;
  logic              exp_value;
  logic              exp_oe;
  int                err_total = 0;
  int                samples_checked = 0;
  int                cycles = 0;

  flag_irq_timer_pins u_flag_irq_timer_pins (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .program_flag_pins_level(flag_level), .program_flag_pins_value(flag_value),
    .program_flag_pins_oe(flag_oe), .flag_cond(flag_cond), .interrupt_request_pins_n(irq_n),
    .irq_to_core(irq_to_core), .vectors_ready(vectors_ready), .timer0_expired(timer0_expired),
    .timer_expire_out_level(exp_level), .timer_expire_out_value(exp_value),
    .timer_expire_out_oe(exp_oe));

  pin_partner u_pin_partner (.clock(clock), .reset(reset), .flag_drive(flag_drive),
    .flag_drive_en(flag_drive_en), .flag_dut_value(flag_value), .flag_dut_oe(flag_oe),
    .flag_level(flag_level), .irq_n_cmd(irq_n_cmd), .irq_n(irq_n), .strap(strap),
    .expire_value(exp_value), .expire_oe(exp_oe), .expire_level(exp_level));

  // ---------------------------------------------
  // clock, watchdog and verdict
  // ---------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // the whole run needs under a hundred cycles; this only catches a hang
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      stop_test();
    end
  end

  // ---------------------------------------------
  // bus and timing helpers
  // ---------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic do_reset(input logic s, input logic v);
    @(posedge clock);
    reset <= 1'b1;
    strap <= s;
    vectors_ready <= v;
    edges(4);
    `CHECK(flag_oe, 4'h0)
    `CHECK(exp_oe, 1'b0)
    `CHECK(irq_to_core, 4'h0)
    @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    `CHECK(exp_oe, 1'b0)
    edges(1);
    `CHECK(exp_oe, 1'b1)
    rd(OFS_STATUS, rv);
    `CHECK(rv, {29'h0, v, (s == STRAP_IRQ_BOOT) & v, s})
  endtask

  task automatic flags_test();
    wr(OFS_FLAG_OUT, 32'h4);
    wr(OFS_FLAG_DIR, 32'h5);
    `CHECK(flag_oe, 4'h5)
    `CHECK(flag_value, 4'h4)
    @(posedge clock);
    flag_drive_en <= 4'hA;
    flag_drive <= 4'h8;
    edges(1);
    `CHECK(flag_cond, 4'hE)
    edges(1);
    `CHECK(flag_cond, 4'hC)
    rd(OFS_FLAG_IN, rv);
    `CHECK(rv, 32'hC)
    rd(8'h1C, rv);
    `CHECK(rv, 32'h0)
  endtask

  task automatic irq_level_test();
    wr(OFS_IRQ_EN, 32'h1);
    @(posedge clock);
    irq_n_cmd <= 4'hC;
    edges(1);
    `CHECK(irq_to_core, 4'h0)
    edges(1);
    `CHECK(irq_to_core, 4'h1)
    @(posedge clock);
    irq_n_cmd <= 4'hF;
    edges(2);
    `CHECK(irq_to_core, 4'h0)
  endtask

  task automatic irq_edge_test();
    wr(OFS_IRQ_MODE, 32'h2);
    wr(OFS_IRQ_EN, 32'h3);
    @(posedge clock);
    irq_n_cmd <= 4'hD;
    @(posedge clock);
    irq_n_cmd <= 4'hF;
    edges(1);
    `CHECK(irq_to_core, 4'h0)
    edges(1);
    `CHECK(irq_to_core, 4'h2)
    edges(3);
    `CHECK(irq_to_core, 4'h2)
    rd(OFS_IRQ_PEND, rv);
    `CHECK(rv, 32'h2)
    wr(OFS_IRQ_PEND, 32'h2);
    `CHECK(irq_to_core, 4'h0)
    // the clear lands on the very edge that captures a new fall: the capture must win
    @(posedge clock);
    irq_n_cmd <= 4'hD;
    @(posedge clock);
    irq_n_cmd <= 4'hF;
    wr(OFS_IRQ_PEND, 32'h2);
    `CHECK(irq_to_core, 4'h2)
    wr(OFS_IRQ_PEND, 32'h2);
    `CHECK(irq_to_core, 4'h0)
  endtask

  task automatic timer_test();
    @(posedge clock);
    timer0_expired <= 1'b1;
    @(posedge clock);
    timer0_expired <= 1'b0;
    @(negedge clock);
    `CHECK(exp_value, 1'b1)
    `CHECK(exp_level, 1'b1)
    edges(1);
    `CHECK(exp_value, 1'b0)
  endtask

  task automatic boot_test();
    // second reset with flags still outputs proves they fall back to inputs
    do_reset(STRAP_IRQ_BOOT, 1'b1);
    @(posedge clock);
    irq_n_cmd <= 4'h7;
    edges(2);
    `CHECK(irq_to_core, 4'h8)
    @(posedge clock);
    irq_n_cmd <= 4'hF;
    edges(2);
  endtask

  initial begin
    reset = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    flag_drive = 4'h0;
    flag_drive_en = 4'h0;
    irq_n_cmd = 4'hF;
    vectors_ready = 1'b0;
    timer0_expired = 1'b0;
    strap = 1'b1;
    do_reset(~STRAP_IRQ_BOOT, 1'b0);
    flags_test();
    irq_level_test();
    irq_edge_test();
    timer_test();
    boot_test();
    stop_test();
  end
endmodule
